//--- src/pshz_ctrl.v
// Issue serialization and hazard control for a single-issue core
`timescale 1ns/1ps
`include "pshz_defines.vh"

// Overview of operation
// - Multiply blocks one clock before multiply, two clocks before divide.
// - Buffered store frees pipeline; next bus access waits for free bus.
// - Writes to regs 1, 18, 19 fully serialize; reads wait loads/stores.
// - Writes to 144-151, 158 and state register fetch serialize.
// - Regs 152-157, 159: write fetch serialize, read waits loads/stores.
// - Move-to 268 or 269 raises emulation exception, time base kept.
// - Time-base read of 284 or 285 raises emulation exception.
// - Version register 287 access never serializes.
// - Condition register serializes only for move-to-fields.
// - Dependent use of internal zero-wait load gets exactly one bubble.
// - Single-cycle wins write-back bus; multiply deferred one clock.
// - Load and single-cycle write back together in separate ticks.
// - Fastest external load dependent gets three bubbles.
// - Full history buffer stalls issue; one extra bubble after free.
// - Store behind unfinished float waits write-back; issue goes on.
// - Branch unit runs in parallel from prefetch queue, bubbles overlap.
// - Unresolved compare: predict, fetch, hold queue without executing.
// - Compare write-back re-evaluates; correct prediction continues.
module pshz_ctrl (
    input wire core_clk,
    input wire sys_rst,
    input wire iss_valid,
    input wire iss_is_spr,
    input wire iss_spr_write,
    input wire iss_spr_tb_read,
    input wire [`PSHZ_SPR_W-1:0] iss_spr_num,
    input wire iss_is_msr_write,
    input wire iss_is_cr_fields,
    input wire iss_is_mul,
    input wire iss_is_div,
    input wire iss_is_single,
    input wire iss_is_load,
    input wire iss_load_ext,
    input wire iss_is_store,
    input wire iss_uses_load,
    input wire iss_is_branch,
    input wire iss_is_float,
    input wire iss_dep_cmp,
    input wire iss_predict_taken,
    input wire lsu_busy,
    input wire bus_free,
    input wire pipe_idle,
    input wire hb_full,
    input wire hb_wb_free,
    input wire fp_wb_done,
    input wire cmp_wb,
    input wire cmp_taken,
    output reg issue_stall,
    output reg fetch_serialize,
    output reg emul_exc,
    output reg tb_update_en,
    output reg mul_wb_defer,
    output reg load_wb_tick,
    output reg store_bus_go,
    output reg branch_hold,
    output reg queue_flush,
    output reg refetch_req,
    output reg ser_active
);

    localparam ST_RUN = 3'b001;
    localparam ST_SER = 3'b010;
    localparam ST_LDST = 3'b100;

    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [1:0] blk_q;
    reg [1:0] load_bub_q;
    reg load_dst_pend_q;
    reg hb_wait_q;
    reg hb_retire_q;
    reg store_pend_q;
    reg fp_pend_q;
    reg pred_pend_q;
    reg pred_dir_q;
    reg mul_wb_q;

    reg [2:0] ser_cls;
    reg tb_emul;
    wire [`PSHZ_SPR_W-1:0] n;

    assign n = iss_spr_num;

    // -------------------------------------------------
    // Serialization class decode
    // -------------------------------------------------
    always @* begin
        ser_cls = `PSHZ_SER_NONE;
        tb_emul = 1'b0;
        if (iss_valid && iss_is_spr) begin
            if (n == `PSHZ_SPR_INT_EXC || n == `PSHZ_SPR_DFSTAT ||
                n == `PSHZ_SPR_FADDR) begin
                ser_cls = iss_spr_write ? `PSHZ_SER_FULL
                                        : `PSHZ_SER_LDST;
            end else if ((n >= `PSHZ_SPR_CMP_A && n <= `PSHZ_SPR_CNT_B) ||
                         n == `PSHZ_SPR_IB_CTL) begin
                if (iss_spr_write)
                    ser_cls = `PSHZ_SER_FETCH;
            end else if ((n >= `PSHZ_SPR_CMP_E && n <= `PSHZ_SPR_LB_TWO) ||
                         n == `PSHZ_SPR_BRK_ADR) begin
                ser_cls = iss_spr_write ? `PSHZ_SER_FETCH
                                        : `PSHZ_SER_LDST;
            end else if (n == `PSHZ_SPR_TB_RD_LO ||
                         n == `PSHZ_SPR_TB_RD_HI) begin
                if (iss_spr_write)
                    tb_emul = 1'b1;
            end else if (n == `PSHZ_SPR_TB_WR_LO ||
                         n == `PSHZ_SPR_TB_WR_HI) begin
                if (iss_spr_tb_read)
                    tb_emul = 1'b1;
                else if (iss_spr_write)
                    ser_cls = `PSHZ_SER_STORE;
            end else if (n == `PSHZ_SPR_VERSION) begin
                ser_cls = `PSHZ_SER_NONE;
            end else if (n == `PSHZ_SPR_DEVPORT) begin
                ser_cls = `PSHZ_SER_FULL;
            end else if (n == `PSHZ_SPR_LINK || n == `PSHZ_SPR_LOOP) begin
                ser_cls = `PSHZ_SER_NONE;
            end else if (n >= `PSHZ_SPR_IC_CST && n <= `PSHZ_SPR_IC_DAT) begin
                if (iss_spr_write)
                    ser_cls = `PSHZ_SER_STORE;
            end else if (n == `PSHZ_SPR_DOWN || n == `PSHZ_SPR_SR0 ||
                         n == `PSHZ_SPR_SR1 ||
                         (n >= `PSHZ_SPR_IRQ_EN && n <= `PSHZ_SPR_NONREC) ||
                         (n >= `PSHZ_SPR_SCR_0 && n <= `PSHZ_SPR_SCR_3) ||
                         n == `PSHZ_SPR_FP_CAUSE) begin
                if (iss_spr_write)
                    ser_cls = `PSHZ_SER_FULL;
            end
        end else if (iss_valid && iss_is_msr_write) begin
            ser_cls = `PSHZ_SER_FETCH;
        end else if (iss_valid && iss_is_cr_fields) begin
            ser_cls = `PSHZ_SER_FULL;
        end
    end

    // -------------------------------------------------
    // Serialization state machine
    // -------------------------------------------------
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (ser_cls == `PSHZ_SER_FULL ||
                    ser_cls == `PSHZ_SER_FETCH)
                    state_d = ST_SER;
                else if (ser_cls == `PSHZ_SER_LDST)
                    state_d = ST_LDST;
            end
            ST_SER: begin
                if (pipe_idle && !lsu_busy)
                    state_d = ST_RUN;
            end
            ST_LDST: begin
                if (!lsu_busy)
                    state_d = ST_RUN;
            end
            default: state_d = ST_RUN;
        endcase
    end

    wire hazard_stall;
    assign hazard_stall = (blk_q != 2'h0) || (load_bub_q != 2'h0) ||
                          hb_wait_q || hb_retire_q || hb_full;

    // -------------------------------------------------
    // Hazard and output registers
    // -------------------------------------------------
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ST_RUN;
            blk_q <= 2'h0;
            load_bub_q <= 2'h0;
            load_dst_pend_q <= 1'b0;
            hb_wait_q <= 1'b0;
            hb_retire_q <= 1'b0;
            store_pend_q <= 1'b0;
            fp_pend_q <= 1'b0;
            pred_pend_q <= 1'b0;
            pred_dir_q <= 1'b0;
            mul_wb_q <= 1'b0;
            issue_stall <= 1'b0;
            fetch_serialize <= 1'b0;
            emul_exc <= 1'b0;
            tb_update_en <= 1'b0;
            mul_wb_defer <= 1'b0;
            load_wb_tick <= 1'b0;
            store_bus_go <= 1'b0;
            branch_hold <= 1'b0;
            queue_flush <= 1'b0;
            refetch_req <= 1'b0;
            ser_active <= 1'b0;
        end else begin
            state_q <= state_d;
            ser_active <= (state_d != ST_RUN);
            fetch_serialize <= (state_q == ST_RUN) &&
                               (ser_cls == `PSHZ_SER_FETCH);
            emul_exc <= tb_emul;
            tb_update_en <= iss_valid && iss_is_spr && iss_spr_write &&
                            !tb_emul &&
                            ser_cls == `PSHZ_SER_STORE;
            // Multiply blockage by successor
            if (blk_q != 2'h0)
                blk_q <= blk_q - 2'h1;
            else if (iss_valid && iss_is_mul)
                blk_q <= iss_is_div ? `PSHZ_MUL_DIV_BLK
                                    : `PSHZ_MUL_MUL_BLK;
            // Load-use bubbles
            if (load_bub_q != 2'h0)
                load_bub_q <= load_bub_q - 2'h1;
            else if (iss_valid && iss_uses_load && load_dst_pend_q)
                load_bub_q <= iss_load_ext ? `PSHZ_EXT_LOAD_BUB
                                           : `PSHZ_INT_LOAD_BUB;
            load_dst_pend_q <= iss_valid && iss_is_load;
            // Write-back bus arbitration
            mul_wb_q <= iss_valid && iss_is_mul;
            mul_wb_defer <= mul_wb_q && iss_valid && iss_is_single;
            load_wb_tick <= iss_valid && iss_is_load && iss_is_single;
            // History buffer full
            if (hb_full)
                hb_wait_q <= 1'b1;
            else if (hb_wait_q && hb_wb_free)
                hb_wait_q <= 1'b0;
            hb_retire_q <= hb_wait_q && hb_wb_free;
            // Store ordering
            if (fp_wb_done)
                fp_pend_q <= 1'b0;
            if (iss_valid && iss_is_float)
                fp_pend_q <= 1'b1;
            if (iss_valid && iss_is_store)
                store_pend_q <= 1'b1;
            else if (store_bus_go)
                store_pend_q <= 1'b0;
            store_bus_go <= store_pend_q && bus_free && !store_bus_go &&
                            (!fp_pend_q || fp_wb_done);
            // Branch prediction
            queue_flush <= 1'b0;
            refetch_req <= 1'b0;
            if (pred_pend_q && cmp_wb) begin
                pred_pend_q <= 1'b0;
                if (cmp_taken != pred_dir_q) begin
                    queue_flush <= 1'b1;
                    refetch_req <= 1'b1;
                end
            end else if (iss_valid && iss_is_branch && iss_dep_cmp) begin
                pred_pend_q <= 1'b1;
                pred_dir_q <= iss_predict_taken;
            end
            branch_hold <= (pred_pend_q && !cmp_wb) ||
                           (iss_valid && iss_is_branch && iss_dep_cmp);
            // Branches are not counted in hazard stalls
            issue_stall <= hazard_stall || (state_d != ST_RUN);
        end
    end

endmodule

//--- src/pshz_defines.vh
// Constants for the pipeline serialization and hazard control block
`ifndef PSHZ_DEFINES_VH
`define PSHZ_DEFINES_VH

`define PSHZ_SPR_W 10
// Register numbers
`define PSHZ_SPR_INT_EXC 10'h001
`define PSHZ_SPR_LINK 10'h008
`define PSHZ_SPR_LOOP 10'h009
`define PSHZ_SPR_DFSTAT 10'h012
`define PSHZ_SPR_FADDR 10'h013
`define PSHZ_SPR_DOWN 10'h016
`define PSHZ_SPR_SR0 10'h01A
`define PSHZ_SPR_SR1 10'h01B
`define PSHZ_SPR_IRQ_EN 10'h050
`define PSHZ_SPR_IRQ_DIS 10'h051
`define PSHZ_SPR_NONREC 10'h052
`define PSHZ_SPR_CMP_A 10'h090
`define PSHZ_SPR_CMP_D 10'h093
`define PSHZ_SPR_CAUSE 10'h094
`define PSHZ_SPR_DBG_EN 10'h095
`define PSHZ_SPR_CNT_A 10'h096
`define PSHZ_SPR_CNT_B 10'h097
`define PSHZ_SPR_CMP_E 10'h098
`define PSHZ_SPR_LB_TWO 10'h09D
`define PSHZ_SPR_IB_CTL 10'h09E
`define PSHZ_SPR_BRK_ADR 10'h09F
`define PSHZ_SPR_TB_RD_LO 10'h10C
`define PSHZ_SPR_TB_RD_HI 10'h10D
`define PSHZ_SPR_SCR_0 10'h110
`define PSHZ_SPR_SCR_3 10'h113
`define PSHZ_SPR_TB_WR_LO 10'h11C
`define PSHZ_SPR_TB_WR_HI 10'h11D
`define PSHZ_SPR_VERSION 10'h11F
`define PSHZ_SPR_IC_CST 10'h230
`define PSHZ_SPR_IC_DAT 10'h232
`define PSHZ_SPR_DEVPORT 10'h276
`define PSHZ_SPR_FP_CAUSE 10'h3FE

// Serialization classes
`define PSHZ_SER_NONE 3'h0
`define PSHZ_SER_FULL 3'h1
`define PSHZ_SER_FETCH 3'h2
`define PSHZ_SER_LDST 3'h3
`define PSHZ_SER_STORE 3'h4

// Hazard counts in clocks or bubbles
`define PSHZ_MUL_MUL_BLK 2'h1
`define PSHZ_MUL_DIV_BLK 2'h2
`define PSHZ_INT_LOAD_BUB 2'h1
`define PSHZ_EXT_LOAD_BUB 2'h3
`define PSHZ_HB_RETIRE_BUB 2'h1

`endif

//--- verif/pshz_ctrl_props.sv
// Assertion checker for the serialization and hazard block
`timescale 1ns/1ps
`include "pshz_defines.vh"
module pshz_ctrl_props (
    input wire core_clk,
    input wire sys_rst,
    input wire iss_valid,
    input wire iss_is_spr,
    input wire iss_spr_write,
    input wire iss_spr_tb_read,
    input wire [`PSHZ_SPR_W-1:0] iss_spr_num,
    input wire iss_is_cr_fields,
    input wire pipe_idle,
    input wire lsu_busy,
    input wire cmp_wb,
    input wire ser_active,
    input wire issue_stall,
    input wire fetch_serialize,
    input wire emul_exc,
    input wire tb_update_en,
    input wire branch_hold,
    input wire queue_flush,
    input wire refetch_req
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire mv = iss_valid && iss_is_spr;
    wire [9:0] n = iss_spr_num;
    a_tb_write_trap: assert property (mv && iss_spr_write && (n == 10'h10C ||
        n == 10'h10D) |=> emul_exc && !tb_update_en)
        else $error("time-base write not trapped");
    a_tb_read_trap: assert property (iss_valid && iss_spr_tb_read &&
        (n == 10'h11C || n == 10'h11D) |=> emul_exc)
        else $error("time-base read not trapped");
    a_full_write_ser: assert property (mv && iss_spr_write && (n == 10'h001
        || n == 10'h012 || n == 10'h013) |=> ser_active && issue_stall)
        else $error("full serialization missing");
    a_fetch_write_ser: assert property (mv && iss_spr_write && ((n >= 10'h090
        && n <= 10'h097) || n == 10'h09E) |=> fetch_serialize)
        else $error("fetch serialization missing");
    a_version_no_ser: assert property (mv && n == 10'h11F && !ser_active
        |=> !ser_active && !fetch_serialize)
        else $error("version access serialized");
    a_link_count_free: assert property (mv && (n == 10'h008 || n == 10'h009)
        && !ser_active |=> !ser_active && !fetch_serialize)
        else $error("link or count access serialized");
    a_cr_fields_ser: assert property (iss_valid && iss_is_cr_fields
        |=> ser_active)
        else $error("condition field move not serialized");
    a_ser_release: assert property (ser_active && pipe_idle && !lsu_busy &&
        !iss_valid |=> !ser_active)
        else $error("serialization held too long");
    a_hold_resolve: assert property (branch_hold && cmp_wb && !iss_valid
        |=> !branch_hold)
        else $error("branch hold not released");
    a_flush_refetch: assert property (queue_flush |-> refetch_req)
        else $error("flush without refetch");
endmodule
bind pshz_ctrl pshz_ctrl_props i_pshz_ctrl_props (.*);

//--- verif/pshz_lsu_model.sv
// Behavioural load/store bus and pipeline status model
`timescale 1ns/1ps
module pshz_lsu_model (
    input wire core_clk,
    input wire sys_rst,
    input wire store_bus_go,
    input wire bus_hold,
    input wire pipe_busy,
    output wire lsu_busy,
    output wire bus_free,
    output wire pipe_idle
);
    reg [1:0] busy_q;
    // Each started store occupies the bus two cycles
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst)
            busy_q <= 2'h0;
        else if (store_bus_go)
            busy_q <= 2'h2;
        else if (busy_q != 2'h0)
            busy_q <= busy_q - 2'h1;
    end
    assign lsu_busy = bus_hold || busy_q != 2'h0;
    assign bus_free = !lsu_busy;
    assign pipe_idle = !pipe_busy && !lsu_busy;
endmodule

//--- verif/test_pipeline_serialization_hazards.sv
// Self-checking bench for the serialization and hazard block
`timescale 1ns/1ps
`include "pshz_defines.vh"
module test_pipeline_serialization_hazards;
    logic core_clk = 0;
    logic sys_rst = 1;
    logic iss_valid, iss_is_spr, iss_spr_write, iss_spr_tb_read;
    logic iss_is_msr_write, iss_is_cr_fields, iss_is_mul, iss_is_div;
    logic iss_is_single, iss_is_load, iss_load_ext, iss_is_store;
    logic iss_uses_load, iss_is_branch, iss_is_float, iss_dep_cmp;
    logic iss_predict_taken, hb_full, hb_wb_free, fp_wb_done, cmp_wb;
    logic cmp_taken, bus_hold, pipe_busy;
    logic [`PSHZ_SPR_W-1:0] iss_spr_num;
    wire lsu_busy, bus_free, pipe_idle, issue_stall, fetch_serialize;
    wire emul_exc, tb_update_en, mul_wb_defer, load_wb_tick, store_bus_go;
    wire branch_hold, queue_flush, refetch_req, ser_active;
    int mismatches = 0;
    int total_checks = 0;
    int n;
    pshz_ctrl i_pshz_ctrl (.*);
    pshz_lsu_model i_pshz_lsu_model (.*);
    always #20 core_clk = ~core_clk;
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
        total_checks++;
        if (seen !== e) begin
            mismatches++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, seen);
        end
    endtask
    task clr;
        {iss_valid, iss_is_spr, iss_spr_write, iss_spr_tb_read, iss_spr_num,
            iss_is_msr_write, iss_is_cr_fields, iss_is_mul, iss_is_div,
            iss_is_single, iss_is_load, iss_load_ext, iss_is_store,
            iss_uses_load, iss_is_branch, iss_is_float, iss_dep_cmp,
            iss_predict_taken, hb_full, hb_wb_free, fp_wb_done, cmp_wb,
            cmp_taken} <= '0;
    endtask
    task fire;
        @(posedge core_clk);
        clr;
        #1;
    endtask
    task stalls;
        n = 0;
        repeat (6) begin
            n += (issue_stall === 1'b1);
            @(posedge core_clk);
            #1;
        end
    endtask
    task spr(input logic [9:0] r, input logic w, t, input logic [2:0] e, m);
        @(posedge core_clk);
        {iss_valid, iss_is_spr, iss_spr_write, iss_spr_tb_read} <= {2'h3, w, t};
        iss_spr_num <= r;
        fire;
        chk("ser fetch emul", {ser_active, fetch_serialize, emul_exc} & m, e);
        repeat (3) @(posedge core_clk);
    endtask
    task t_mul(input logic d);
        @(posedge core_clk);
        {iss_valid, iss_is_mul, iss_is_div} <= {2'h3, d};
        fire;
        stalls;
        chk("mul block", n, d ? 2 : 1);
    endtask
    task t_load(input logic e, dep);
        @(posedge core_clk);
        {iss_valid, iss_is_load, iss_load_ext} <= {2'h3, e};
        @(posedge core_clk);
        {iss_is_load, iss_uses_load} <= {1'b0, dep};
        fire;
        stalls;
        chk("load bubbles", n, dep ? (e ? 3 : 1) : 0);
    endtask
    task t_store(input logic f);
        logic g;
        g = 0;
        @(posedge core_clk);
        {iss_valid, iss_is_float, bus_hold} <= {2'h3, !f};
        @(posedge core_clk);
        {iss_is_float, iss_is_store} <= 2'h1;
        fire;
        repeat (4) begin
            g |= store_bus_go;
            chk("stall", issue_stall, 0);
            @(posedge core_clk);
            #1;
        end
        chk("early store", g, 0);
        bus_hold <= 0;
        fp_wb_done <= 1;
        repeat (6) begin
            @(posedge core_clk);
            fp_wb_done <= 0;
            #1;
            g |= store_bus_go;
        end
        chk("store go", g, 1);
    endtask
    task t_branch(input logic t);
        @(posedge core_clk);
        {iss_valid, iss_is_branch, iss_dep_cmp, iss_predict_taken} <= 4'hF;
        fire;
        repeat (2) @(posedge core_clk);
        #1;
        chk("hold", branch_hold, 1);
        @(posedge core_clk);
        {cmp_wb, cmp_taken} <= {1'b1, t};
        fire;
        chk("flush", {queue_flush, refetch_req}, t ? 0 : 3);
        repeat (3) @(posedge core_clk);
    endtask
    task t_wb;
        @(posedge core_clk);
        {iss_valid, iss_is_mul} <= 2'h3;
        @(posedge core_clk);
        {iss_is_mul, iss_is_single, iss_is_load} <= 3'h3;
        fire;
        chk("mul wb defer", mul_wb_defer, 1);
        chk("load wb tick", load_wb_tick, 1);
        repeat (3) @(posedge core_clk);
        {iss_valid, iss_is_spr, iss_spr_write} <= 3'h7;
        iss_spr_num <= `PSHZ_SPR_TB_WR_LO;
        fire;
        chk("tb update", {tb_update_en, emul_exc}, 2);
        repeat (3) @(posedge core_clk);
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #100000;
        mismatches++;
        conclude;
    end
    initial begin
        clr;
        bus_hold = 0;
        pipe_busy = 0;
        repeat (10) @(posedge core_clk);
        sys_rst <= 0;
        spr(`PSHZ_SPR_INT_EXC, 1, 0, 3'h4, 3'h7);
        spr(`PSHZ_SPR_FADDR, 1, 0, 3'h4, 3'h7);
        spr(`PSHZ_SPR_CMP_D, 1, 0, 3'h2, 3'h3);
        spr(`PSHZ_SPR_IB_CTL, 1, 0, 3'h2, 3'h3);
        spr(`PSHZ_SPR_BRK_ADR, 1, 0, 3'h2, 3'h3);
        spr(`PSHZ_SPR_VERSION, 0, 0, 3'h0, 3'h7);
        spr(`PSHZ_SPR_TB_RD_LO, 1, 0, 3'h1, 3'h1);
        spr(`PSHZ_SPR_TB_WR_HI, 0, 1, 3'h1, 3'h1);
        spr(`PSHZ_SPR_LINK, 1, 0, 3'h0, 3'h7);
        spr(`PSHZ_SPR_DEVPORT, 0, 0, 3'h4, 3'h4);
        spr(`PSHZ_SPR_DOWN, 1, 0, 3'h4, 3'h4);
        @(posedge core_clk);
        {pipe_busy, iss_valid, iss_is_cr_fields} <= 3'h7;
        fire;
        chk("cr ser", ser_active, 1);
        repeat (2) @(posedge core_clk);
        #1;
        chk("ser stall", issue_stall, 1);
        @(posedge core_clk);
        pipe_busy <= 0;
        @(posedge core_clk);
        #1;
        chk("ser end", ser_active, 0);
        t_mul(0);
        t_mul(1);
        for (int i = 0; i < 4; i++) t_load(i[0], i[1]);
        t_store(0);
        t_store(1);
        t_branch(1);
        t_branch(0);
        t_wb;
        @(posedge core_clk);
        hb_full <= 1;
        repeat (2) @(posedge core_clk);
        #1;
        chk("hb stall", issue_stall, 1);
        {hb_full, hb_wb_free} <= 2'h1;
        fire;
        // Cycle of the freeing write-back itself is still stalled
        @(posedge core_clk);
        #1;
        stalls;
        chk("hb bubble", n, 1);
        conclude;
    end
endmodule
